// >>> dv/ssc_ctl_model.sv
// bus controller model sending program codes and data bytes
`timescale 1ns/1ps
`default_nettype none
module ssc_ctl_model (
    // clock
    input wire logic ref_clk,
    // bytes towards the block
    output ssc_pkg::ssc_rx_t rx
);
    initial rx = '0;
    task automatic put(input logic d, input logic [7:0] b);
        @(posedge ref_clk);
        rx <= '{1'b1, d, b};
        @(posedge ref_clk);
        rx <= '{1'b0, d, ~b}; // released byte keeps no stale value
    endtask
    task automatic code(input string s);
        for (int i = 0; i < s.len(); i++) put(1'b0, s[i]);
    endtask
    task automatic mask_load(input logic [4:0] en);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < 5; i++) if (en[i]) b = b + (8'h01 << i);
        code("@1");
        put(1'b1, b);
    endtask
endmodule // ssc_ctl_model
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the status and cal control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic has_d = 1'b0;
    logic neg = 1'b0;
    logic [15:0] tenths = 16'h0000;
    logic lost = 1'b0;
    logic [15:0] offv = 16'h0000;
    ssc_pkg::ssc_rx_t rx;
    ssc_pkg::ssc_cond_t cond = '0;
    ssc_pkg::ssc_analog_t ana = '0;
    logic [7:0] ssb, mask, ecode;
    logic srq, srq_oe_n, busy, ext, osc, rauto, gload, pre, rvq;
    ssc_pkg::ssc_trig_t trig;
    ssc_pkg::ssc_get_t get;
    logic [15:0] ref_f, off_a;
    int err_total = 0, checked = 0, oscn, gn;
    always #12.5 ref_clk = ~ref_clk;
    ssc_ctl_model ctl_u (.ref_clk(ref_clk), .rx(rx));
    ssc_status_cal #(.ERR57_CYCLES(20)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .rx(rx),
        .num_has_digits(has_d), .num_negative(neg), .num_tenths(tenths), .cond(cond),
        .analog(ana), .settings_lost(lost), .range_auto_user(1'b0), .offset_value(offv),
        .service_status_byte(ssb), .service_mask(mask), .srq_out(srq), .srq_oe_n(srq_oe_n),
        .trigger_mode(trig), .get_mode(get), .reference_factor(ref_f), .offset_applied(off_a),
        .cal_busy(busy), .cal_external(ext), .osc_on(osc), .range_auto(rauto),
        .gain_load(gload), .error_code(ecode), .preset_pulse(pre), .mask_readback_req(rvq));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d errors=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(input ssc_pkg::ssc_cond_t c);
        @(posedge ref_clk);
        cond <= c;
        @(posedge ref_clk);
        cond <= '0;
        wt(2);
    endtask
    task automatic cmd(input string s);
        ctl_u.code(s);
        wt(3);
    endtask
    task automatic start_cal(input logic d, input logic n, input logic [15:0] v);
        @(posedge ref_clk);
        has_d <= d;
        neg <= n;
        tenths <= v;
        ctl_u.code("CL");
        ctl_u.code("EN");
        wt(1);
    endtask
    task automatic finish_cal;
        int i;
        oscn = 0;
        gn = 0;
        for (i = 0; i < 200 && busy !== 1'b0; i++) begin
            wt(1);
            oscn += osc;
            gn += gload;
        end
        if (i == 200) begin
            err_total++;
            close_out;
        end
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wt(2);
        chk(ssb, 16'h0000);
        chk(mask, 16'h0000);
        ctl_u.mask_load(5'h05);
        wt(3);
        chk(mask, 16'h0005);
        pulse(4'b0100);
        chk(ssb, 16'h0008);
        chk(srq, 16'h0000);
        pulse(4'b1000);
        chk(ssb, 16'h0049);
        chk({srq, srq_oe_n}, 16'h0002);
        wt(5);
        chk(ssb, 16'h0049);
        cmd("CS");
        chk({ssb, srq}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            cmd($sformatf("TR%0d", i));
            chk(trig, i[15:0]);
        end
        for (int i = 0; i < 3; i++) begin
            cmd($sformatf("GT%0d", i));
            chk(get, i[15:0]);
        end
        start_cal(1'b1, 1'b0, 16'h04b1);
        wt(2);
        chk({busy, ssb}, 16'h0044);
        chk(ref_f, 16'h03e8);
        cmd("CS");
        ana <= 2'b11;
        start_cal(1'b1, 1'b0, 16'h03d9);
        chk({busy, rauto}, 16'h0003);
        finish_cal;
        chk({oscn > 1, gn[0]}, 16'h0003);
        chk({osc, rauto}, 16'h0000);
        chk(ssb, 16'h0002);
        start_cal(1'b1, 1'b1, 16'h03d9);
        chk(ext, 16'h0001);
        finish_cal;
        chk(oscn, 16'h0000);
        @(posedge ref_clk);
        lost <= 1'b1;
        wt(20);
        chk(ecode, 16'h0039);
        wt(1);
        chk({pre, ecode}, 16'h0100);
        chk(ref_f, 16'h03e8);
        cmd("CS");
        ana <= 2'b10;
        start_cal(1'b1, 1'b0, 16'h02bc);
        cmd("TR1");
        chk({busy, trig}, 16'h0001);
        chk(ref_f, 16'h02bc);
        chk(ssb, 16'h0000);
        cmd("PR");
        chk(ref_f, 16'h03e8);
        offv <= 16'h0123;
        cmd("OS");
        chk(off_a, 16'h0000);
        cmd("EN");
        chk(off_a, 16'h0123);
        ana <= 2'b11;
        start_cal(1'b0, 1'b0, 16'h0000);
        chk(ref_f, 16'h03e8);
        chk(busy, 16'h0001);
        finish_cal;
        close_out;
    end
endmodule // tb
`default_nettype wire

// >>> rtl/ssc_decode.sv
// two- and three-character program code decoder
`timescale 1ns/1ps
`default_nettype none
module ssc_decode (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // received bytes
    input wire ssc_pkg::ssc_rx_t rx,
    // decoded code, one-cycle pulse
    output ssc_pkg::ssc_cmd_t cmd,
    output logic cmd_valid
);
    logic [7:0] first;
    logic have_first;
    logic [7:0] next_first;
    logic next_have_first;
    ssc_pkg::ssc_cmd_t next_cmd;
    logic next_cmd_valid;

    function automatic ssc_pkg::ssc_cmd_t lookup(input logic [7:0] a, input logic [7:0] b);
        unique case ({a, b})
            {"@", "1"}: lookup = ssc_pkg::SSC_CMD_MASK_PREFIX;
            {"R", "V"}: lookup = ssc_pkg::SSC_CMD_MASK_READBACK;
            {"C", "S"}: lookup = ssc_pkg::SSC_CMD_CLEAR_STATUS;
            {"E", "N"}: lookup = ssc_pkg::SSC_CMD_COMMIT;
            {"C", "L"}: lookup = ssc_pkg::SSC_CMD_REF_FACTOR;
            {"P", "R"}: lookup = ssc_pkg::SSC_CMD_DEFAULT_STATE;
            {"O", "S"}: lookup = ssc_pkg::SSC_CMD_OFFSET;
            default: lookup = ssc_pkg::SSC_CMD_OTHER;
        endcase
    endfunction

    // third char selects trigger, get and oscillator variants
    function automatic ssc_pkg::ssc_cmd_t lookup3(input logic [7:0] a, input logic [7:0] b,
                                                  input logic [7:0] c);
        unique case ({a, b, c})
            {"T", "R", "0"}: lookup3 = ssc_pkg::SSC_CMD_TRIG_HOLD;
            {"T", "R", "1"}: lookup3 = ssc_pkg::SSC_CMD_TRIG_IMM;
            {"T", "R", "2"}: lookup3 = ssc_pkg::SSC_CMD_TRIG_DLY;
            {"T", "R", "3"}: lookup3 = ssc_pkg::SSC_CMD_TRIG_FREE;
            {"G", "T", "0"}: lookup3 = ssc_pkg::SSC_CMD_GET_IGN;
            {"G", "T", "1"}: lookup3 = ssc_pkg::SSC_CMD_GET_IMM;
            {"G", "T", "2"}: lookup3 = ssc_pkg::SSC_CMD_GET_DLY;
            {"O", "C", "0"}: lookup3 = ssc_pkg::SSC_CMD_OSC_OFF;
            {"O", "C", "1"}: lookup3 = ssc_pkg::SSC_CMD_OSC_ON;
            default: lookup3 = ssc_pkg::SSC_CMD_NONE;
        endcase
    endfunction

    logic [7:0] second;
    logic have_second;
    logic [7:0] next_second;
    logic next_have_second;

    always_comb begin
        next_first = first;
        next_have_first = have_first;
        next_second = second;
        next_have_second = have_second;
        next_cmd = ssc_pkg::SSC_CMD_NONE;
        next_cmd_valid = 1'b0;
        if (rx.valid && !rx.is_data) begin
            if (!have_first) begin
                next_first = rx.data;
                next_have_first = 1'b1;
            end else if (!have_second) begin
                if (first == "T" || first == "G" || (first == "O" && rx.data == "C")) begin
                    next_second = rx.data;
                    next_have_second = 1'b1;
                end else begin
                    next_cmd = lookup(first, rx.data);
                    next_cmd_valid = 1'b1;
                    next_have_first = 1'b0;
                end
            end else begin
                next_cmd = lookup3(first, second, rx.data);
                if (next_cmd == ssc_pkg::SSC_CMD_NONE) begin
                    next_cmd = ssc_pkg::SSC_CMD_OTHER;
                end
                next_cmd_valid = 1'b1;
                next_have_first = 1'b0;
                next_have_second = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            first <= 8'h00;
            have_first <= 1'b0;
            second <= 8'h00;
            have_second <= 1'b0;
            cmd <= ssc_pkg::SSC_CMD_NONE;
            cmd_valid <= 1'b0;
        end else begin
            first <= next_first;
            have_first <= next_have_first;
            second <= next_second;
            have_second <= next_have_second;
            cmd <= next_cmd;
            cmd_valid <= next_cmd_valid;
        end
    end
endmodule // ssc_decode
`default_nettype wire

// >>> rtl/ssc_map.svh
// register, code and timing constants for the status and cal control block
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
`define SSC_BIT_READY 0
`define SSC_BIT_CALDONE 1
`define SSC_BIT_ENTRY 2
`define SSC_BIT_MEAS 3
`define SSC_BIT_LIMIT 4
`define SSC_BIT_RQS 6
`define SSC_COND_MASK 8'h1f
`define SSC_MASK_RESET 8'h00
`define SSC_STATUS_RESET 8'h00
`define SSC_REF_PRESET 16'h03e8
`define SSC_REF_MIN 16'h01f4
`define SSC_REF_MAX 16'h04b0
`define SSC_ERR57_CODE 8'h39
`define SSC_ERR57_TIME_MS 2000
`define SSC_CLK_HZ 40000000
`define SSC_ERR57_CYCLES (`SSC_ERR57_TIME_MS * (`SSC_CLK_HZ / 1000))
`endif

// >>> rtl/ssc_pkg.sv
// types for the status and cal control block
package ssc_pkg;
    typedef enum logic [4:0] {
        SSC_CMD_NONE = 5'h00,
        SSC_CMD_MASK_PREFIX = 5'h01,
        SSC_CMD_MASK_READBACK = 5'h02,
        SSC_CMD_CLEAR_STATUS = 5'h03,
        SSC_CMD_COMMIT = 5'h04,
        SSC_CMD_REF_FACTOR = 5'h05,
        SSC_CMD_DEFAULT_STATE = 5'h06,
        SSC_CMD_TRIG_HOLD = 5'h07,
        SSC_CMD_TRIG_IMM = 5'h08,
        SSC_CMD_TRIG_DLY = 5'h09,
        SSC_CMD_TRIG_FREE = 5'h0a,
        SSC_CMD_GET_IGN = 5'h0b,
        SSC_CMD_GET_IMM = 5'h0c,
        SSC_CMD_GET_DLY = 5'h0d,
        SSC_CMD_OFFSET = 5'h0e,
        SSC_CMD_OSC_OFF = 5'h0f,
        SSC_CMD_OSC_ON = 5'h10,
        SSC_CMD_OTHER = 5'h1f
    } ssc_cmd_t;
    typedef enum logic [1:0] {
        SSC_TRIG_HOLD = 2'h0,
        SSC_TRIG_IMM = 2'h1,
        SSC_TRIG_DLY = 2'h2,
        SSC_TRIG_FREE = 2'h3
    } ssc_trig_t;
    typedef enum logic [1:0] {
        SSC_GET_IGN = 2'h0,
        SSC_GET_IMM = 2'h1,
        SSC_GET_DLY = 2'h2
    } ssc_get_t;
    typedef enum logic [5:0] {
        SSC_CAL_IDLE = 6'h01,
        SSC_CAL_PROBE_ON = 6'h02,
        SSC_CAL_PROBE_OFF = 6'h04,
        SSC_CAL_RUN = 6'h08,
        SSC_CAL_DONE = 6'h10,
        SSC_CAL_FAIL = 6'h20
    } ssc_cal_st_t;
    typedef struct packed {
        logic valid;
        logic is_data;
        logic [7:0] data;
    } ssc_rx_t;
    typedef struct packed {
        logic data_ready;
        logic meas_error;
        logic limit_error;
        logic entry_error;
    } ssc_cond_t;
    typedef struct packed {
        logic power_step_seen;
        logic gain_done;
    } ssc_analog_t;
endpackage : ssc_pkg

// >>> rtl/ssc_status_cal.sv
// status byte, service-request mask and reference-calibration sequencer
// Contract
// - masked high conditions raise service request; unmasked still set status bits
// - mask loads from the one byte sent right after the mask prefix
// - service-request flag at weight 64 true when any enabled condition set
// - condition and service-request flags stick until status byte cleared
// - status positions of weight 128 and 32 read zero
// - bus service-request line follows the service-request flag exactly
// - status-clear code clears status byte and withdraws service request
// - value codes act only once the commit code arrives
// - decode four trigger modes and three group-trigger responses
// - reference factor outside 50.0 to 120.0 percent magnitude is entry error
// - negative reference factor calibrates against external source, oscillator unused
// - positive reference factor calibrates against internal 1.00 mW oscillator
// - preset stores 100 percent reference factor, gain untouched
// - reference code committed without digits calibrates with last stored factor
// - any command other than the commit during calibration aborts it, then executes
// - aborted calibration still keeps the newly entered factor
// - offset settings not applied during calibration
// - autorange forced during calibration, previous range restored afterwards
// - internal calibration first toggles oscillator, proceeds only on power change
// - oscillator returns to its prior state after internal calibration
// - lost settings raise error 57, cleared after two seconds or new function
`include "ssc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ssc_status_cal #(
    parameter int ERR57_CYCLES = `SSC_ERR57_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // bus bytes: program code characters or data bytes
    input wire ssc_pkg::ssc_rx_t rx,
    // numeric entry in tenths of a percent, sign separate
    input wire logic num_has_digits,
    input wire logic num_negative,
    input wire logic [15:0] num_tenths,
    // measurement-side conditions as one-cycle pulses, then analog, lost-settings, range and offset levels
    input wire ssc_pkg::ssc_cond_t cond,
    input wire ssc_pkg::ssc_analog_t analog,
    input wire logic settings_lost,
    input wire logic range_auto_user,
    input wire logic [15:0] offset_value,
    // status and service request
    output logic [7:0] service_status_byte,
    output logic [7:0] service_mask,
    output logic srq_out,
    output logic srq_oe_n,
    // configuration
    output ssc_pkg::ssc_trig_t trigger_mode,
    output ssc_pkg::ssc_get_t get_mode,
    output logic [15:0] reference_factor,
    output logic [15:0] offset_applied,
    // calibration controls
    output logic cal_busy,
    output logic cal_external,
    output logic osc_on,
    output logic range_auto,
    output logic gain_load,
    output logic [7:0] error_code,
    output logic preset_pulse,
    output logic mask_readback_req
);
    ssc_pkg::ssc_cmd_t cmd;
    logic cmd_valid;

    ssc_decode u_decode (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .rx(rx),
        .cmd(cmd),
        .cmd_valid(cmd_valid)
    );

    function automatic logic in_range(input logic [15:0] v);
        in_range = (v >= `SSC_REF_MIN) && (v <= `SSC_REF_MAX);
    endfunction

    ssc_pkg::ssc_cal_st_t cal_st, next_cal_st;
    logic [4:0] cond_bits, next_cond_bits;
    logic service_request_flag, next_rqs;
    logic [7:0] next_mask;
    logic mask_pending, next_mask_pending;
    ssc_pkg::ssc_cmd_t pend, next_pend;
    ssc_pkg::ssc_trig_t next_trig;
    ssc_pkg::ssc_get_t next_get;
    logic [15:0] next_ref;
    logic ref_neg, next_ref_neg;
    logic [15:0] next_offset;
    logic osc_user, next_osc_user;
    logic next_osc_on;
    logic next_gain_load;
    logic [7:0] next_error;
    logic [31:0] err_cnt, next_err_cnt;
    logic lost_seen, next_lost_seen;
    logic next_preset;
    logic next_readback;
    logic new_cmd;
    logic [4:0] set_bits;

    assign new_cmd = cmd_valid && cmd != ssc_pkg::SSC_CMD_COMMIT;

    // status and mask
    always_comb begin
        set_bits = '0;
        set_bits[`SSC_BIT_READY] = cond.data_ready;
        set_bits[`SSC_BIT_MEAS] = cond.meas_error;
        set_bits[`SSC_BIT_LIMIT] = cond.limit_error;
        set_bits[`SSC_BIT_ENTRY] = cond.entry_error;
        // cal completion flag only from normal finish
        set_bits[`SSC_BIT_CALDONE] = (cal_st == ssc_pkg::SSC_CAL_DONE);
        if (cmd_valid && cmd == ssc_pkg::SSC_CMD_COMMIT && pend == ssc_pkg::SSC_CMD_REF_FACTOR
            && num_has_digits && !in_range(num_tenths)) begin
            set_bits[`SSC_BIT_ENTRY] = 1'b1;
        end
        next_cond_bits = cond_bits;
        if (cmd_valid && cmd == ssc_pkg::SSC_CMD_CLEAR_STATUS) begin
            next_cond_bits = '0;
        end
        next_cond_bits = next_cond_bits | set_bits;
        next_mask = service_mask;
        next_mask_pending = mask_pending;
        if (cmd_valid && cmd == ssc_pkg::SSC_CMD_MASK_PREFIX) begin
            next_mask_pending = 1'b1;
        end else if (rx.valid && rx.is_data && mask_pending) begin
            next_mask = rx.data;
            next_mask_pending = 1'b0;
        end else if (cmd_valid) begin
            next_mask_pending = 1'b0;
        end
        // new mask counts at once, so a stored flag it enables raises rqs with it
        next_rqs = (cmd_valid && cmd == ssc_pkg::SSC_CMD_CLEAR_STATUS) ? 1'b0 : service_request_flag;
        if (|(next_cond_bits & next_mask[4:0])) begin
            next_rqs = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cond_bits <= '0;
            service_request_flag <= 1'b0;
            service_mask <= `SSC_MASK_RESET;
            mask_pending <= 1'b0;
        end else begin
            cond_bits <= next_cond_bits;
            service_request_flag <= next_rqs;
            service_mask <= next_mask;
            mask_pending <= next_mask_pending;
        end
    end

    // bits of weight 128 and 32 are tied low
    assign service_status_byte = {1'b0, service_request_flag, 1'b0, cond_bits};
    assign srq_out = service_request_flag;
    assign srq_oe_n = ~service_request_flag;

    // command execution and calibration
    always_comb begin
        next_pend = pend;
        next_trig = trigger_mode;
        next_get = get_mode;
        next_ref = reference_factor;
        next_ref_neg = ref_neg;
        next_offset = offset_applied;
        next_osc_user = osc_user;
        next_cal_st = cal_st;
        next_gain_load = 1'b0;
        next_preset = 1'b0;
        next_readback = 1'b0;
        next_error = error_code;
        next_err_cnt = err_cnt;
        next_lost_seen = lost_seen;
        if (cmd_valid) begin
            unique case (cmd)
                ssc_pkg::SSC_CMD_TRIG_HOLD: next_trig = ssc_pkg::SSC_TRIG_HOLD;
                ssc_pkg::SSC_CMD_TRIG_IMM: next_trig = ssc_pkg::SSC_TRIG_IMM;
                ssc_pkg::SSC_CMD_TRIG_DLY: next_trig = ssc_pkg::SSC_TRIG_DLY;
                ssc_pkg::SSC_CMD_TRIG_FREE: next_trig = ssc_pkg::SSC_TRIG_FREE;
                ssc_pkg::SSC_CMD_GET_IGN: next_get = ssc_pkg::SSC_GET_IGN;
                ssc_pkg::SSC_CMD_GET_IMM: next_get = ssc_pkg::SSC_GET_IMM;
                ssc_pkg::SSC_CMD_GET_DLY: next_get = ssc_pkg::SSC_GET_DLY;
                ssc_pkg::SSC_CMD_OSC_OFF: next_osc_user = 1'b0;
                ssc_pkg::SSC_CMD_OSC_ON: next_osc_user = 1'b1;
                ssc_pkg::SSC_CMD_MASK_READBACK: next_readback = 1'b1;
                ssc_pkg::SSC_CMD_DEFAULT_STATE: begin
                    next_ref = `SSC_REF_PRESET;
                    next_ref_neg = 1'b0;
                    next_preset = 1'b1;
                end
                ssc_pkg::SSC_CMD_REF_FACTOR,
                ssc_pkg::SSC_CMD_OFFSET: next_pend = cmd;
                ssc_pkg::SSC_CMD_COMMIT: begin
                    // value codes act only on the commit
                    if (pend == ssc_pkg::SSC_CMD_OFFSET && cal_st == ssc_pkg::SSC_CAL_IDLE) begin
                        next_offset = offset_value;
                    end else if (pend == ssc_pkg::SSC_CMD_REF_FACTOR) begin
                        if (!num_has_digits) begin
                            next_cal_st = ref_neg ? ssc_pkg::SSC_CAL_RUN
                                                  : ssc_pkg::SSC_CAL_PROBE_ON;
                        end else if (in_range(num_tenths)) begin
                            next_ref = num_tenths;
                            next_ref_neg = num_negative;
                            next_cal_st = num_negative ? ssc_pkg::SSC_CAL_RUN
                                                       : ssc_pkg::SSC_CAL_PROBE_ON;
                        end
                    end
                    next_pend = ssc_pkg::SSC_CMD_NONE;
                end
                default: next_pend = ssc_pkg::SSC_CMD_NONE;
            endcase
            if (new_cmd) begin
                next_error = 8'h00;
            end
        end
        // abort on any command other than the commit
        if (new_cmd && cal_st != ssc_pkg::SSC_CAL_IDLE) begin
            next_cal_st = ssc_pkg::SSC_CAL_IDLE;
        end else if (!cmd_valid) begin
            unique case (cal_st)
                ssc_pkg::SSC_CAL_IDLE: next_cal_st = ssc_pkg::SSC_CAL_IDLE;
                ssc_pkg::SSC_CAL_PROBE_ON: next_cal_st = ssc_pkg::SSC_CAL_PROBE_OFF;
                ssc_pkg::SSC_CAL_PROBE_OFF: next_cal_st = analog.power_step_seen
                    ? ssc_pkg::SSC_CAL_RUN : ssc_pkg::SSC_CAL_FAIL;
                ssc_pkg::SSC_CAL_RUN: if (analog.gain_done) begin
                    next_cal_st = ssc_pkg::SSC_CAL_DONE;
                    next_gain_load = 1'b1;
                end
                ssc_pkg::SSC_CAL_DONE: next_cal_st = ssc_pkg::SSC_CAL_IDLE;
                ssc_pkg::SSC_CAL_FAIL: next_cal_st = ssc_pkg::SSC_CAL_IDLE;
                default: next_cal_st = ssc_pkg::SSC_CAL_IDLE;
            endcase
        end
        // lost-settings error with timed clear
        if (settings_lost && !lost_seen) begin
            next_lost_seen = 1'b1;
            next_error = `SSC_ERR57_CODE;
            next_err_cnt = '0;
        end else if (error_code == `SSC_ERR57_CODE) begin
            if (err_cnt == 32'(ERR57_CYCLES - 1)) begin
                next_error = 8'h00;
            end else begin
                next_err_cnt = err_cnt + 32'h1;
            end
        end
        if (error_code == `SSC_ERR57_CODE && next_error == 8'h00) begin
            next_ref = `SSC_REF_PRESET;
            next_ref_neg = 1'b0;
            next_preset = 1'b1;
        end
    end

    always_comb begin
        unique case (cal_st)
            ssc_pkg::SSC_CAL_PROBE_ON: next_osc_on = 1'b1;
            ssc_pkg::SSC_CAL_PROBE_OFF: next_osc_on = 1'b0;
            ssc_pkg::SSC_CAL_RUN: next_osc_on = !ref_neg;
            default: next_osc_on = osc_user;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend <= ssc_pkg::SSC_CMD_NONE;
            trigger_mode <= ssc_pkg::SSC_TRIG_FREE;
            get_mode <= ssc_pkg::SSC_GET_IGN;
            reference_factor <= `SSC_REF_PRESET;
            ref_neg <= 1'b0;
            offset_applied <= 16'h0000;
            osc_user <= 1'b0;
            osc_on <= 1'b0;
            cal_st <= ssc_pkg::SSC_CAL_IDLE;
            gain_load <= 1'b0;
            error_code <= 8'h00;
            err_cnt <= '0;
            lost_seen <= 1'b0;
            preset_pulse <= 1'b0;
            mask_readback_req <= 1'b0;
        end else begin
            pend <= next_pend;
            trigger_mode <= next_trig;
            get_mode <= next_get;
            reference_factor <= next_ref;
            ref_neg <= next_ref_neg;
            offset_applied <= next_offset;
            osc_user <= next_osc_user;
            osc_on <= next_osc_on;
            cal_st <= next_cal_st;
            gain_load <= next_gain_load;
            error_code <= next_error;
            err_cnt <= next_err_cnt;
            lost_seen <= next_lost_seen;
            preset_pulse <= next_preset;
            mask_readback_req <= next_readback;
        end
    end

    assign cal_busy = (cal_st != ssc_pkg::SSC_CAL_IDLE);
    assign cal_external = ref_neg;
    // autorange forced while busy, user setting otherwise
    assign range_auto = cal_busy ? 1'b1 : range_auto_user;

    srq_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        srq_out == service_status_byte[6]) else $error("srq line differs from flag");
    zero_bits_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        service_status_byte[7] == 1'b0 && service_status_byte[5] == 1'b0)
        else $error("reserved status bits set");
    rqs_sticky_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        service_request_flag && !(cmd_valid && cmd == ssc_pkg::SSC_CMD_CLEAR_STATUS) |=> service_request_flag)
        else $error("service request dropped");
    rqs_cause_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        |(cond_bits & service_mask[4:0]) |-> service_request_flag) else $error("enabled flag without rqs");
    clear_status_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cmd_valid && cmd == ssc_pkg::SSC_CMD_CLEAR_STATUS && set_bits == '0
        && cal_st == ssc_pkg::SSC_CAL_IDLE |=> cond_bits == '0)
        else $error("clear status ignored");
    abort_cal_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        new_cmd && cal_busy |=> cal_st == ssc_pkg::SSC_CAL_IDLE && !gain_load)
        else $error("calibration not aborted");
    autorange_cal_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cal_busy |-> range_auto) else $error("autorange not forced");
    offset_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cal_busy |=> offset_applied == $past(offset_applied))
        else $error("offset changed during calibration");
    osc_restore_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cal_st == ssc_pkg::SSC_CAL_DONE ##1 cal_st == ssc_pkg::SSC_CAL_IDLE |=> osc_on == osc_user)
        else $error("oscillator not restored");
    preset_ref_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cmd_valid && cmd == ssc_pkg::SSC_CMD_DEFAULT_STATE |=> reference_factor == `SSC_REF_PRESET
        && !gain_load) else $error("preset factor wrong");
endmodule // ssc_status_cal
`default_nettype wire
